/* logic/plmp_regs.svh */
// offsets, fields, reset values and timing counts of the local master port
`ifndef PLMP_REGS_SVH
`define PLMP_REGS_SVH

`define PLMP_ADDR_W          8
`define PLMP_OFS_CTRL        8'h00
`define PLMP_OFS_STATUS      8'h04
`define PLMP_CTRL_RST        32'h0000_4000

`define PLMP_CTRL_BM_EN      0
`define PLMP_CTRL_MWI_EN     1
`define PLMP_CTRL_BUS64      2
`define PLMP_CTRL_FBB_EN     3
`define PLMP_CTRL_LAT_LSB    8
`define PLMP_CTRL_LINE_LSB   16

`define PLMP_PH_ADDR         4'h1
`define PLMP_PH_BUS          4'h2
`define PLMP_PH_TERM         4'h4
`define PLMP_PH_FBB          4'h8

`define PLMP_END_NORMAL      3'h0
`define PLMP_END_TIMEOUT     3'h1
`define PLMP_END_NO_TARGET   3'h2
`define PLMP_END_TGT_ABORT   3'h3
`define PLMP_END_RETRY       3'h4
`define PLMP_END_DISCONNECT  3'h5
`define PLMP_END_GNT_ABORT   3'h6
`define PLMP_END_LOCAL       3'h7

`define PLMP_MAX_BURST       13'h1000
`define PLMP_CLAIM_WINDOW    3'h5

`endif

/* logic/plmp_pkg.sv */
// types of the local master port
package plmp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_TERM,
        ST_FBB
    } plmp_state_t;
endpackage

/* logic/plmp_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module plmp_sync3 #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // pin and result
    input  wire logic pin_i,
    output logic      level_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s1_r    <= RST_VAL;
            s2_r    <= RST_VAL;
            s3_r    <= RST_VAL;
            level_r <= RST_VAL;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end

    assign level_o = level_r;
endmodule

/* logic/plmp_master_port.sv */
// local master side of the bus core: request, grant, pacing and termination report
//
// Behaviour
// - request low lines; grant output tells bus granted
// - phase count zero means 4096 phases
// - strobe marks each consumed or presented word
// - strobe used only with 32-bit local bus
// - direction high for read, low write
// - timer-expired output on latency timer timeout
// - one-hot phase state: address, bus, end, back-to-back
// - end cause three bits, eight ascending codes
// - expiry on final phase: timeout, normal cause
// - expiry before final phase: timeout cause
// - unclaimed transaction reports no target code
// - narrow request loads counter with phase count
// - wide request: count, or doubled if unconfirmed
// - write-invalidate flags expiry only at line boundaries, never ends on it
// - read strobe only when data bus valid
`timescale 1ns/1ns
`include "plmp_regs.svh"
module plmp_master_port (
    // clock and reset
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_n_i,
    // register port
    input  wire logic [`PLMP_ADDR_W-1:0]  reg_addr_i,
    input  wire logic [31:0]              reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output logic [31:0]                   reg_rdata_o,
    // bus side
    input  wire logic                     pci_gnt_n_i,
    output logic                          pci_req_n_o,
    input  wire logic                     tgt_claim_i,
    input  wire logic                     tgt_ready_i,
    input  wire logic                     tgt_ack64_i,
    input  wire logic                     tgt_abort_i,
    input  wire logic                     tgt_retry_i,
    input  wire logic                     tgt_disconnect_i,
    // local master requests
    input  wire logic                     narrow_request_n_i,
    input  wire logic                     wide_request_n_i,
    input  wire logic                     master_read_i,
    input  wire logic                     master_mwi_i,
    input  wire logic [11:0]              master_phase_count_i,
    input  wire logic                     master_side_ready_n_i,
    input  wire logic                     master_cancel_n_i,
    // local master status
    output logic                          local_grant_n_o,
    output logic                          wide_transfer_ack_n_o,
    output logic                          master_xfer_strobe_n_o,
    output logic                          master_direction_o,
    output logic                          master_timer_expired_n_o,
    output logic [3:0]                    master_phase_state_o,
    output logic [2:0]                    master_end_cause_o,
    output logic [12:0]                   remaining_phase_counter_o
);
    plmp_pkg::plmp_state_t state_r;
    plmp_pkg::plmp_state_t state_nxt;

    logic        gnt_n_s;
    logic [31:0] ctrl_r;
    logic [31:0] rdata_r;
    logic        pci_req_n_r;
    logic        lgnt_n_r;
    logic        dir_r;
    logic        mwi_r;
    logic        wide_r;
    logic        ack64_r;
    logic        claimed_r;
    logic [2:0]  claim_cnt_r;
    logic [7:0]  lat_r;
    logic [7:0]  line_pos_r;
    logic        tmo_r;
    logic        cancel_pend_r;
    logic [2:0]  cause_r;
    logic [12:0] cnt_r;
    logic [12:0] cnt_nxt;
    logic [2:0]  cause_nxt;
    logic        end_now;

    // bus pin crosses into this clock
    plmp_sync3 #(
        .RST_VAL (1'b1)
    ) u_gnt_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (pci_gnt_n_i),
        .level_o   (gnt_n_s)
    );

    // control fields
    wire       bm_en    = ctrl_r[`PLMP_CTRL_BM_EN];
    wire       mwi_en   = ctrl_r[`PLMP_CTRL_MWI_EN];
    wire       bus64    = ctrl_r[`PLMP_CTRL_BUS64];
    wire       fbb_en   = ctrl_r[`PLMP_CTRL_FBB_EN];
    wire [7:0] lat_init = ctrl_r[`PLMP_CTRL_LAT_LSB +: 8];
    wire [7:0] line_sz  = ctrl_r[`PLMP_CTRL_LINE_LSB +: 8];

    // request decode
    wire narrow_req = !narrow_request_n_i;
    wire wide_req   = !wide_request_n_i;
    wire req_any    = narrow_req || wide_req;
    wire granted    = !gnt_n_s;

    wire [12:0] len_ext = (master_phase_count_i == 12'h000) ?
                          `PLMP_MAX_BURST : {1'b0, master_phase_count_i};

    // data phase handshake
    wire in_data   = (state_r == plmp_pkg::ST_DATA);
    wire xfer      = in_data && claimed_r && tgt_ready_i && !master_side_ready_n_i;
    wire last_ph   = (cnt_r == 13'h0001);
    wire expired   = (lat_r == 8'h00);
    wire tmo_cond  = expired && gnt_n_s;
    wire line_end  = (line_sz == 8'h00) || (line_pos_r == line_sz - 8'h01);
    wire mwi_cur   = mwi_r && mwi_en;
    wire cancel    = !master_cancel_n_i || cancel_pend_r;
    wire new_claim = in_data && !claimed_r && tgt_claim_i;
    wire no_target = in_data && !claimed_r && !tgt_claim_i &&
                     (claim_cnt_r == `PLMP_CLAIM_WINDOW - 3'h1);

    // termination decision, highest priority first
    always_comb begin
        end_now   = 1'b0;
        cause_nxt = cause_r;
        if (in_data) begin
            if (claimed_r && tgt_abort_i) begin
                end_now   = 1'b1;
                cause_nxt = `PLMP_END_TGT_ABORT;
            end else if (claimed_r && tgt_retry_i) begin
                end_now   = 1'b1;
                cause_nxt = `PLMP_END_RETRY;
            end else if (no_target) begin
                end_now   = 1'b1;
                cause_nxt = `PLMP_END_NO_TARGET;
            end else if (xfer && last_ph) begin
                end_now   = 1'b1;
                cause_nxt = `PLMP_END_NORMAL;
            end else if (claimed_r && tgt_disconnect_i) begin
                end_now   = 1'b1;
                cause_nxt = `PLMP_END_DISCONNECT;
            end else if (cancel && (!mwi_cur || (xfer && line_end))) begin
                end_now   = 1'b1;
                cause_nxt = `PLMP_END_LOCAL;
            end else if (tmo_cond && !mwi_cur) begin
                end_now   = 1'b1;
                cause_nxt = `PLMP_END_TIMEOUT;
            end
        end else if (state_r == plmp_pkg::ST_ADDR && gnt_n_s) begin
            end_now   = 1'b1;
            cause_nxt = `PLMP_END_GNT_ABORT;
        end
    end

    // phase sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            plmp_pkg::ST_IDLE: begin
                if (req_any && bm_en && granted) begin
                    state_nxt = plmp_pkg::ST_ADDR;
                end
            end
            plmp_pkg::ST_ADDR: begin
                state_nxt = end_now ? plmp_pkg::ST_TERM : plmp_pkg::ST_DATA;
            end
            plmp_pkg::ST_DATA: begin
                if (end_now) begin
                    state_nxt = plmp_pkg::ST_TERM;
                end
            end
            plmp_pkg::ST_TERM: begin
                if (fbb_en && bm_en && req_any && granted) begin
                    state_nxt = plmp_pkg::ST_FBB;
                end else begin
                    state_nxt = plmp_pkg::ST_IDLE;
                end
            end
            plmp_pkg::ST_FBB: begin
                state_nxt = plmp_pkg::ST_ADDR;
            end
            default: begin
                state_nxt = plmp_pkg::ST_IDLE;
            end
        endcase
    end

    // remaining-phase counter
    always_comb begin
        cnt_nxt = cnt_r;
        if (state_r == plmp_pkg::ST_ADDR) begin
            cnt_nxt = len_ext;
        end else if (new_claim && wide_r && !tgt_ack64_i) begin
            cnt_nxt = {cnt_r[11:0], 1'b0};
        end else if (xfer) begin
            cnt_nxt = cnt_r - 13'h0001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_r <= plmp_pkg::ST_IDLE;
            cnt_r   <= 13'h0000;
            cause_r <= `PLMP_END_NORMAL;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            if (end_now) begin
                cause_r <= cause_nxt;
            end
        end
    end

    // transaction attributes, captured when the address phase starts
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            dir_r  <= 1'b0;
            mwi_r  <= 1'b0;
            wide_r <= 1'b0;
        end else if (state_nxt == plmp_pkg::ST_ADDR && state_r != plmp_pkg::ST_ADDR) begin
            dir_r  <= master_read_i;
            mwi_r  <= master_mwi_i && !master_read_i;
            wide_r <= wide_req;
        end
    end

    // claim tracking and 64-bit confirmation
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            claimed_r   <= 1'b0;
            claim_cnt_r <= 3'h0;
            ack64_r     <= 1'b0;
        end else if (state_r == plmp_pkg::ST_ADDR) begin
            claimed_r   <= 1'b0;
            claim_cnt_r <= 3'h0;
            ack64_r     <= 1'b0;
        end else if (new_claim) begin
            claimed_r <= 1'b1;
            ack64_r   <= wide_r && tgt_ack64_i;
        end else if (in_data && !claimed_r) begin
            claim_cnt_r <= claim_cnt_r + 3'h1;
        end
    end

    // latency timer, line position, timeout and deferred cancel
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            lat_r         <= 8'h00;
            line_pos_r    <= 8'h00;
            tmo_r         <= 1'b0;
            cancel_pend_r <= 1'b0;
        end else if (state_r == plmp_pkg::ST_ADDR) begin
            lat_r         <= lat_init;
            line_pos_r    <= 8'h00;
            tmo_r         <= 1'b0;
            cancel_pend_r <= 1'b0;
        end else if (in_data) begin
            if (!expired) begin
                lat_r <= lat_r - 8'h01;
            end
            if (xfer) begin
                line_pos_r <= line_end ? 8'h00 : line_pos_r + 8'h01;
            end
            if (tmo_cond && (!mwi_cur || (xfer && line_end))) begin
                tmo_r <= 1'b1;
            end
            if (mwi_cur && !master_cancel_n_i) begin
                cancel_pend_r <= 1'b1;
            end
        end
    end

    // bus request and local grant
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pci_req_n_r <= 1'b1;
            lgnt_n_r    <= 1'b1;
        end else begin
            pci_req_n_r <= !(req_any && bm_en && state_r == plmp_pkg::ST_IDLE);
            lgnt_n_r    <= !(granted && state_nxt == plmp_pkg::ST_ADDR);
        end
    end

    // register port
    wire sel_ctrl   = (reg_addr_i == `PLMP_OFS_CTRL);
    wire sel_status = (reg_addr_i == `PLMP_OFS_STATUS);
    wire [31:0] status_word = {3'h0, cnt_r, 7'h00, ack64_r, tmo_r,
                               cause_r, master_phase_state_o};
    wire [31:0] rd_mux = sel_ctrl   ? ctrl_r :
                         sel_status ? status_word : 32'h0000_0000;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ctrl_r  <= `PLMP_CTRL_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            if (reg_wr_i && sel_ctrl) begin
                ctrl_r <= reg_wdata_i;
            end
            rdata_r <= reg_rd_i ? rd_mux : 32'h0000_0000;
        end
    end

    // phase state decode
    logic [3:0] phase_w;
    always_comb begin
        case (state_r)
            plmp_pkg::ST_ADDR: phase_w = `PLMP_PH_ADDR;
            plmp_pkg::ST_DATA: phase_w = `PLMP_PH_BUS;
            plmp_pkg::ST_TERM: phase_w = `PLMP_PH_TERM;
            plmp_pkg::ST_FBB:  phase_w = `PLMP_PH_FBB;
            default:           phase_w = `PLMP_PH_TERM;
        endcase
    end

    // outputs
    assign master_phase_state_o      = phase_w;
    assign master_xfer_strobe_n_o    = !(xfer && !bus64);
    assign master_direction_o        = dir_r;
    assign master_timer_expired_n_o  = !tmo_r;
    assign master_end_cause_o        = cause_r;
    assign remaining_phase_counter_o = cnt_r;
    assign local_grant_n_o           = lgnt_n_r;
    assign wide_transfer_ack_n_o     = !ack64_r;
    assign pci_req_n_o               = pci_req_n_r;
    assign reg_rdata_o               = rdata_r;

    // checks
    chk_strobe_narrow: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !master_xfer_strobe_n_o |-> !bus64 && tgt_ready_i && !master_side_ready_n_i)
        else $error("strobe on wide bus or without both ready");
    chk_phase_onehot: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $onehot(master_phase_state_o))
        else $error("phase state not one-hot");
    chk_zero_len: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_r == plmp_pkg::ST_ADDR && master_phase_count_i == 12'h000
        |=> remaining_phase_counter_o == 13'h1000)
        else $error("zero phase count not loaded as 4096");
    chk_dir_stable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        in_data && $past(in_data) |-> $stable(master_direction_o))
        else $error("direction changed mid transaction");
    chk_count_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        xfer |=> remaining_phase_counter_o == $past(cnt_r) - 13'h0001)
        else $error("counter did not step down by one");
    chk_wide_double: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        new_claim && wide_r && !tgt_ack64_i
        |=> remaining_phase_counter_o == {$past(cnt_r[11:0]), 1'b0})
        else $error("unconfirmed wide request not doubled");
    chk_no_target: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        no_target |=> master_end_cause_o == 3'h2 && master_phase_state_o == 4'h4)
        else $error("unclaimed transaction not reported");
    chk_timeout_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        end_now && cause_nxt == 3'h1 |=> !master_timer_expired_n_o
        && master_phase_state_o == 4'h4)
        else $error("timeout end without timeout flag");
    chk_grant_out: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !local_grant_n_o |-> master_phase_state_o == 4'h1 && $past(granted))
        else $error("local grant without bus grant");
endmodule

/* bench/plmp_backend_model.sv */
// back-end model acting as local master on the request side of the port
`timescale 1ns/1ns
module plmp_backend_model (
    // clock and reset
    input  wire logic   ref_clk_i,
    input  wire logic   rst_n_i,
    // bench control
    input  wire logic   cancel_i,
    input  wire logic   stall_i,
    // port side
    input  wire logic   local_grant_n_i,
    output logic        narrow_request_n_o,
    output logic        wide_request_n_o,
    output logic        master_read_o,
    output logic        master_mwi_o,
    output logic [11:0] master_phase_count_o,
    output logic        master_side_ready_n_o,
    output logic        master_cancel_n_o
);
    initial begin
        narrow_request_n_o = 1'b1;
        wide_request_n_o = 1'b1;
        master_read_o = 1'b0;
        master_mwi_o = 1'b0;
        master_phase_count_o = 12'h001;
        master_side_ready_n_o = 1'b1;
        master_cancel_n_o = 1'b1;
    end

    // random stalls pace the data phases
    always @(posedge ref_clk_i) begin
        master_side_ready_n_o <= stall_i && ($urandom % 4 == 0);
        master_cancel_n_o <= !(cancel_i && rst_n_i);
    end

    // hold request until grant or for at most 60 cycles, drop it one cycle later
    task automatic request(input logic wide, input logic rd, input logic mw,
                           input logic [11:0] cnt, output bit ok);
        ok = 1'b0;
        @(posedge ref_clk_i);
        narrow_request_n_o <= wide;
        wide_request_n_o <= !wide;
        master_read_o <= rd;
        master_mwi_o <= mw;
        master_phase_count_o <= cnt;
        repeat (60) begin
            @(negedge ref_clk_i);
            if (local_grant_n_i === 1'b0) begin
                ok = 1'b1;
                break;
            end
        end
        @(posedge ref_clk_i);
        narrow_request_n_o <= 1'b1;
        wide_request_n_o <= 1'b1;
    endtask
endmodule

/* bench/pci_local_master_port_tb_top.sv */
// self-checking bench of the local master port
`timescale 1ns/1ns
`include "plmp_regs.svh"
module pci_local_master_port_tb_top;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic        pci_gnt_n_i = 1'b1;
    logic        pci_req_n_o;
    logic        tgt_claim_i = 1'b0;
    logic        tgt_ack64_i = 1'b0;
    logic        tgt_abort_i = 1'b0;
    logic        tgt_retry_i = 1'b0;
    logic        tgt_disconnect_i = 1'b0;
    logic        tgt_ready_i = 1'b1;
    logic        cancel = 1'b0;
    logic        req32_n, req64_n, rd, mwi, rdy_n, cancel_n;
    logic [11:0] cnt;
    logic        local_grant_n_o, ack_n, strobe_n, dir, timer_n;
    logic [3:0]  state;
    logic [2:0]  cause;
    logic [12:0] counter, first_cnt;
    logic        first_dir;
    int          num_errors = 0;
    int          comparisons = 0;
    int          words = 0;
    int          sel = 0;
    bit          claim_en = 1'b1;
    bit          drop_g = 1'b0;
    bit          b64 = 1'b0;
    bit          mw_on = 1'b0;

    plmp_master_port DUT (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .pci_gnt_n_i(pci_gnt_n_i), .pci_req_n_o(pci_req_n_o),
        .tgt_claim_i(tgt_claim_i), .tgt_ready_i(tgt_ready_i), .tgt_ack64_i(tgt_ack64_i),
        .tgt_abort_i(tgt_abort_i), .tgt_retry_i(tgt_retry_i),
        .tgt_disconnect_i(tgt_disconnect_i), .narrow_request_n_i(req32_n),
        .wide_request_n_i(req64_n), .master_read_i(rd), .master_mwi_i(mwi),
        .master_phase_count_i(cnt), .master_side_ready_n_i(rdy_n),
        .master_cancel_n_i(cancel_n), .local_grant_n_o(local_grant_n_o),
        .wide_transfer_ack_n_o(ack_n), .master_xfer_strobe_n_o(strobe_n),
        .master_direction_o(dir), .master_timer_expired_n_o(timer_n),
        .master_phase_state_o(state), .master_end_cause_o(cause),
        .remaining_phase_counter_o(counter)
    );

    plmp_backend_model bm (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cancel_i(cancel), .stall_i(1'b1),
        .local_grant_n_i(local_grant_n_o), .narrow_request_n_o(req32_n),
        .wide_request_n_o(req64_n), .master_read_o(rd), .master_mwi_o(mwi),
        .master_phase_count_o(cnt), .master_side_ready_n_o(rdy_n),
        .master_cancel_n_o(cancel_n)
    );

    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // target side: grant follows request, claim in data state, terminations on demand
    always @(posedge ref_clk_i) begin
        pci_gnt_n_i <= (drop_g && words > 0) ? 1'b1 : pci_req_n_o;
        tgt_claim_i <= claim_en && state == `PLMP_PH_BUS;
        tgt_abort_i <= sel == 3 && words > 1;
        tgt_retry_i <= sel == 4 && words > 1;
        tgt_disconnect_i <= sel == 5 && words > 1;
        cancel <= (sel == 7 && words > 1) || (mwi && timer_n === 1'b0);
        tgt_ready_i <= ($urandom % 8) != 0;
    end

    // strobes outside the bus phase carry no data
    always @(negedge ref_clk_i) begin
        if (strobe_n === 1'b0 && state === `PLMP_PH_BUS) begin
            if (words == 0) begin
                first_cnt = counter;
                first_dir = dir;
            end
            words++;
        end
        if (rst_n_i && local_grant_n_o === 1'b0) cmp_port(13'(state), 13'(`PLMP_PH_ADDR));
    end

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: register got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_port(input logic [12:0] got, input logic [12:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: port got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge ref_clk_i);
        d = reg_rdata_o;
    endtask

    // one transaction against the integer model of load, words and cause
    task automatic run(input logic wide, input logic rdx, input logic ack,
                       input logic [11:0] c, input int s, input bit clm, input bit dg);
        int load;
        int n;
        bit ok;
        logic [2:0] ec;
        logic [31:0] st;
        load = (c == 12'h000) ? 4096 : int'(c);
        if (wide && !ack) load = (2 * load) % 8192;
        ec = mw_on ? `PLMP_END_LOCAL :
             (dg ? `PLMP_END_TIMEOUT : (!clm ? `PLMP_END_NO_TARGET : 3'(s)));
        words = 0;
        sel = s;
        claim_en = clm;
        drop_g = dg;
        tgt_ack64_i <= ack;
        bm.request(wide, rdx, mw_on, c, ok);
        cmp_port(13'(ok), 13'h1);
        n = 0;
        do begin
            @(negedge ref_clk_i);
            n++;
        end while (state !== `PLMP_PH_TERM && n < 400);
        cmp_port(13'(n < 400), 13'h0001);
        cmp_port(13'(cause), 13'(ec));
        cmp_port(13'(timer_n), 13'(!(dg || mw_on)));
        if (wide && clm) cmp_port(13'(ack_n), 13'(!ack));
        if (mw_on) cmp_port(13'(words % 4), 13'h0000);
        if (words > 0) cmp_port(first_cnt, 13'(load));
        if (words > 0) cmp_port(13'(first_dir), 13'(rdx));
        if (s == 0 && clm && !dg && !mw_on) begin
            cmp_port(13'(words), 13'(b64 ? 0 : load));
            cmp_port(counter, 13'h0000);
        end
        reg_rd(`PLMP_OFS_STATUS, st);
        cmp_reg({29'h0, st[6:4]}, {29'h0, ec});
        sel = 0;
        drop_g = 1'b0;
        claim_en = 1'b1;
        repeat (4) @(posedge ref_clk_i);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #40000;
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        logic [31:0] d;
        bit ok;
        void'($urandom(22));
        repeat (8) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        reg_rd(`PLMP_OFS_CTRL, d);
        cmp_reg(d, `PLMP_CTRL_RST);
        reg_wr(8'h08, 32'hFFFF_FFFF);
        reg_rd(8'h08, d);
        cmp_reg(d, 32'h0000_0000);
        bm.request(1'b0, 1'b0, 1'b0, 12'h004, ok);
        cmp_port(13'(ok), 13'h0000);
        cmp_port(13'(pci_req_n_o), 13'h0001);
        $display("test registers and refusal done");
        reg_wr(`PLMP_OFS_CTRL, 32'h0000_4001);
        for (int i = 0; i < 4; i++) run(0, 1'($urandom % 2), 0, 12'($urandom_range(1, 8)), 0, 1, 0);
        $display("test narrow bursts done");
        run(1, 0, 0, 12'($urandom_range(1, 6)), 0, 1, 0);
        run(1, 1, 1, 12'($urandom_range(1, 6)), 0, 1, 0);
        $display("test wide bursts done");
        run(0, 0, 0, 12'h000, 7, 1, 0);
        for (int k = 3; k < 8; k++) if (k != 6) run(0, 1'(k % 2), 0, 12'h00A, k, 1, 0);
        run(0, 0, 0, 12'h004, 0, 0, 0);
        $display("test terminations done");
        reg_wr(`PLMP_OFS_CTRL, 32'h0000_0201);
        run(0, 0, 0, 12'h010, 0, 1, 1);
        $display("test timeout done");
        reg_wr(`PLMP_OFS_CTRL, 32'h0004_0203);
        mw_on = 1'b1;
        run(0, 0, 0, 12'h010, 0, 1, 0);
        mw_on = 1'b0;
        $display("test write-invalidate done");
        reg_wr(`PLMP_OFS_CTRL, 32'h0000_4005);
        b64 = 1'b1;
        run(0, 1, 0, 12'h003, 0, 1, 0);
        $display("test wide local bus done");
        finish_test();
    end
endmodule
